// File: logic/strobe_capture_defines.vh
// constants for the strobe read capture block
`ifndef STROBE_CAPTURE_DEFINES_VH
`define STROBE_CAPTURE_DEFINES_VH
`define LR_GROUP_WIDTH     16
`define TB_GROUP_WIDTH     18
`define CAL_CODE_WIDTH     6
`define CAL_CODE_RESET     6'h20
`define CAL_CODE_MAX       6'h3F
`define CAL_CODE_MIN       6'h00
`define CLK_PERIOD_NS      100
`define LOCK_WINDOW_NS     400
`define LOCK_WINDOW_CYCLES (`LOCK_WINDOW_NS / `CLK_PERIOD_NS)
`define IDLE_GAP_NS        1600
`define IDLE_GAP_CYCLES    ((`IDLE_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: logic/calib_loop.v
// calibration delay-locked loop producing a 6-bit delay code
`timescale 1ns/1ns
`include "strobe_capture_defines.vh"
module calib_loop (
  input  wire       clk,
  input  wire       reset,
  input  wire       fb_early,
  input  wire       fb_late,
  output wire [5:0] cal_code
);
  localparam integer WIN_I = `LOCK_WINDOW_CYCLES;
  localparam [2:0]   WIN   = WIN_I[2:0];
  reg [5:0] code_reg;
  reg [5:0] code_next;
  reg [2:0] win_reg;
  reg [2:0] win_next;

  always @* begin
    code_next = code_reg;
    win_next  = win_reg + 3'h1;
    if (win_reg == WIN - 3'h1) begin
      win_next = 3'h0;
      // move the code toward lock with the system clock feedback
      if (fb_late && code_reg != `CAL_CODE_MIN) begin
        code_next = code_reg - 6'h01;
      end else if (fb_early && code_reg != `CAL_CODE_MAX) begin
        code_next = code_reg + 6'h01;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      code_reg <= `CAL_CODE_RESET;
      win_reg  <= 3'h0;
    end else begin
      code_reg <= code_next;
      win_reg  <= win_next;
    end
  end

  assign cal_code = code_reg;
endmodule // calib_loop

// File: logic/ddr_strobe_read_capture.v
// ddr strobe read capture, polarity detect and write transfer strobe
// What this block does
// - left/right groups carry 16 data bits, top/bottom groups carry 18.
// - one strobe delay cell per 16- or 18-cell group.
// - delayed strobe drives a local bus to every cell of its group.
// - local bus strobe clocks read data into each cell's capture registers.
// - strobe goes pad, calibrated delay, then dedicated strobe route.
// - raw strobe also feeds polarity logic for sync registers.
// - delay cell takes its setting from a 6-bit calibration code.
// - two calibration loops, each serving only its own half.
// - calibration loop tracks drift by locking to system clock feedback.
// - polarity picks which system clock edge syncs captured data.
// - polarity is decided anew at every read, not once.
// - detector senses high-to-low preamble edge and sets polarity.
// - a write transfer strobe goes to the group's output buffers.
// - transfer strobe is edge clock shifted 90 degrees by delay block.
// - transfer strobe reaches every output cell of the bus.
// - ddr input uses rise and fall registers, then resyncs both streams.
// - polarity signal inverts or passes the sync register clock.
// - ddr output registers both inputs on rise, clock muxes the pad.
`timescale 1ns/1ns
`include "strobe_capture_defines.vh"
module ddr_strobe_read_capture (
  input  wire        clk,
  input  wire        reset,
  input  wire        strobe_in,
  input  wire        strobe_driven,
  input  wire [17:0] read_data_in,
  input  wire        edge_clock_one,
  input  wire [17:0] out_data_high_phase,
  input  wire [17:0] out_data_low_phase,
  input  wire        half_select,
  input  wire        fb_early_a,
  input  wire        fb_late_a,
  input  wire        fb_early_b,
  input  wire        fb_late_b,
  output reg  [17:0] read_rise_data,
  output reg  [17:0] read_fall_data,
  output reg         read_valid,
  output reg         sync_clock_polarity,
  output reg  [5:0]  active_cal_code,
  output reg  [17:0] write_data_out,
  output reg  [17:0] write_transfer_strobe,
  output reg         read_active
);
  // top/bottom width; a left/right group leaves bits 17:16 unused
  localparam integer GW    = `TB_GROUP_WIDTH;
  localparam integer IDLE_GAP_I = `IDLE_GAP_CYCLES;
  localparam [4:0]   IDLE_GAP   = IDLE_GAP_I[4:0];

  localparam [1:0] ST_IDLE     = 2'h0;
  localparam [1:0] ST_PREAMBLE = 2'h1;
  localparam [1:0] ST_BURST    = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops on strobe, driven and edge clock, change counted when 2nd and 3rd agree; read data two flops
  reg [2:0]  stb_sync_reg;
  reg [2:0]  drv_sync_reg;
  reg [2:0]  ec_sync_reg;
  reg        stb_reg;
  reg        drv_reg;
  reg        ec_reg;
  reg [17:0] dq_s1_reg;
  reg [17:0] dq_s2_reg;

  always @(posedge clk) begin
    if (reset) begin
      stb_sync_reg <= 3'h7;
      drv_sync_reg <= 3'h0;
      ec_sync_reg  <= 3'h0;
      stb_reg      <= 1'b1;
      drv_reg      <= 1'b0;
      ec_reg       <= 1'b0;
      dq_s1_reg    <= 18'h00000;
      dq_s2_reg    <= 18'h00000;
    end else begin
      stb_sync_reg <= {stb_sync_reg[1:0], strobe_in};
      drv_sync_reg <= {drv_sync_reg[1:0], strobe_driven};
      ec_sync_reg  <= {ec_sync_reg[1:0], edge_clock_one};
      if (stb_sync_reg[1] == stb_sync_reg[2]) stb_reg <= stb_sync_reg[2];
      if (drv_sync_reg[1] == drv_sync_reg[2]) drv_reg <= drv_sync_reg[2];
      if (ec_sync_reg[1] == ec_sync_reg[2]) ec_reg <= ec_sync_reg[2];
      dq_s1_reg    <= read_data_in;
      dq_s2_reg    <= dq_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // calibration: two loops, each for its own half of the device
  wire [5:0] code_a;
  wire [5:0] code_b;

  calib_loop loop_a (
    .clk      (clk),
    .reset    (reset),
    .fb_early (fb_early_a),
    .fb_late  (fb_late_a),
    .cal_code (code_a)
  );

  calib_loop loop_b (
    .clk      (clk),
    .reset    (reset),
    .fb_early (fb_early_b),
    .fb_late  (fb_late_b),
    .cal_code (code_b)
  );

  wire [5:0] half_code = half_select ? code_b : code_a;

  //////////////////////////////////////////////////////////////////////////
  // strobe delay cell: one per group, delays raw strobe by the code
  reg  [63:0] dly_line_reg;
  wire        local_strobe_bus;

  always @(posedge clk) begin
    if (reset) begin
      dly_line_reg <= 64'hFFFFFFFFFFFFFFFF;
    end else begin
      dly_line_reg <= {dly_line_reg[62:0], stb_reg};
    end
  end

  assign local_strobe_bus = dly_line_reg[active_cal_code];

  //////////////////////////////////////////////////////////////////////////
  // preamble detect and read state
  reg  [1:0] state_reg;
  reg  [4:0] gap_reg;
  reg        raw_prev_reg;
  reg        bus_prev_reg;
  reg        ec_prev_reg;
  wire       preamble_fall = raw_prev_reg & ~stb_reg & drv_reg;
  wire       bus_rise      = ~bus_prev_reg & local_strobe_bus;
  wire       bus_fall      = bus_prev_reg & ~local_strobe_bus;

  always @(posedge clk) begin
    if (reset) begin
      state_reg           <= ST_IDLE;
      gap_reg             <= 5'h00;
      raw_prev_reg        <= 1'b1;
      bus_prev_reg        <= 1'b1;
      ec_prev_reg         <= 1'b0;
      sync_clock_polarity <= 1'b0;
      active_cal_code     <= `CAL_CODE_RESET;
      read_active         <= 1'b0;
    end else begin
      raw_prev_reg <= stb_reg;
      bus_prev_reg <= local_strobe_bus;
      ec_prev_reg  <= ec_reg;
      case (state_reg)
        ST_IDLE: begin
          read_active     <= 1'b0;
          active_cal_code <= half_code;
          if (preamble_fall) begin
            // strobe phase against clock phase picks the sync edge
            sync_clock_polarity <= ec_reg;
            state_reg           <= ST_PREAMBLE;
            read_active         <= 1'b1;
          end
        end
        ST_PREAMBLE: begin
          gap_reg <= 5'h00;
          if (bus_rise) state_reg <= ST_BURST;
          else if (!drv_reg) state_reg <= ST_IDLE;
        end
        ST_BURST: begin
          // polarity and code held until strobe released or the idle gap runs out
          if (bus_rise || bus_fall) gap_reg <= 5'h00;
          else if (gap_reg != IDLE_GAP) gap_reg <= gap_reg + 5'h01;
          if (!drv_reg || gap_reg == IDLE_GAP) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-bit ddr capture, resync, and ddr output
  reg  [17:0] cap_rise_reg;
  reg  [17:0] cap_fall_reg;
  reg  [17:0] out_hi_reg;
  reg  [17:0] out_lo_reg;
  reg         fall_seen_reg;
  reg         dly_ec_reg;
  wire        sync_edge = sync_clock_polarity ? ~ec_reg : ec_reg;
  wire        sync_now  = fall_seen_reg & sync_edge;
  wire        ec_rise   = ec_reg & ~ec_prev_reg;

  genvar i;
  generate
    for (i = 0; i < GW; i = i + 1) begin : g_cell
      always @(posedge clk) begin
        if (reset) begin
          cap_rise_reg[i]          <= 1'b0;
          cap_fall_reg[i]          <= 1'b0;
          read_rise_data[i]        <= 1'b0;
          read_fall_data[i]        <= 1'b0;
          out_hi_reg[i]            <= 1'b0;
          out_lo_reg[i]            <= 1'b0;
          write_data_out[i]        <= 1'b0;
          write_transfer_strobe[i] <= 1'b0;
        end else begin
          if (bus_rise && state_reg != ST_IDLE) cap_rise_reg[i] <= dq_s2_reg[i];
          if (bus_fall && state_reg == ST_BURST) cap_fall_reg[i] <= dq_s2_reg[i];
          if (sync_now) begin
            read_rise_data[i] <= cap_rise_reg[i];
            read_fall_data[i] <= cap_fall_reg[i];
          end
          if (ec_rise) begin
            out_hi_reg[i] <= out_data_high_phase[i];
            out_lo_reg[i] <= out_data_low_phase[i];
          end
          write_data_out[i] <= ec_reg ? out_hi_reg[i] : out_lo_reg[i];
          // quarter-cycle late copy of edge clock, fanned to every cell
          write_transfer_strobe[i] <= dly_ec_reg;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // 90 degree shift of edge clock: delay by a quarter of measured period
  reg [5:0] ec_cnt_reg;
  reg [5:0] ec_half_reg;
  reg [5:0] since_reg;

  always @(posedge clk) begin
    if (reset) begin
      ec_cnt_reg    <= 6'h00;
      ec_half_reg   <= 6'h00;
      since_reg     <= 6'h00;
      dly_ec_reg    <= 1'b0;
      fall_seen_reg <= 1'b0;
      read_valid    <= 1'b0;
    end else begin
      if (ec_reg != ec_prev_reg) begin
        ec_half_reg <= ec_cnt_reg;
        ec_cnt_reg  <= 6'h00;
        since_reg   <= 6'h00;
      end else begin
        if (ec_cnt_reg != 6'h3F) ec_cnt_reg <= ec_cnt_reg + 6'h01;
        if (since_reg != 6'h3F) since_reg <= since_reg + 6'h01;
        if (since_reg == {1'b0, ec_half_reg[5:1]}) dly_ec_reg <= ec_reg;
      end
      if (bus_fall && state_reg == ST_BURST) fall_seen_reg <= 1'b1;
      else if (sync_now) fall_seen_reg <= 1'b0;
      read_valid <= sync_now;
    end
  end
endmodule // ddr_strobe_read_capture

// File: verification/ddr_strobe_read_capture_sva.sv
// port assertions for the strobe read capture block
`timescale 1ns/1ns
module ddr_strobe_read_capture_sva (
  input wire        clk,
  input wire        reset,
  input wire        strobe_in,
  input wire        strobe_driven,
  input wire        read_valid,
  input wire        read_active,
  input wire        sync_clock_polarity,
  input wire [5:0]  active_cal_code,
  input wire [17:0] write_transfer_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  AST_CODE_AFTER_RESET: assert property ($fell(reset) |-> active_cal_code == 6'h20)
    else $error("delay code not at its reset value");
  AST_XFER_ALL_BITS: assert property (write_transfer_strobe == {18{write_transfer_strobe[0]}})
    else $error("transfer strobe bits differ");
  AST_POL_HOLD: assert property (read_active && $past(read_active) |-> $stable(sync_clock_polarity))
    else $error("polarity moved inside a burst");
  AST_CODE_HOLD: assert property (read_active && $past(read_active) |-> $stable(active_cal_code))
    else $error("delay code moved inside a burst");
  AST_PREAMBLE_DETECT: assert property ($fell(strobe_in) && strobe_driven && !read_active |-> ##[2:7] read_active)
    else $error("preamble not detected");
  AST_NO_UNDRIVEN_READ: assert property ($rose(read_active) |-> $past(strobe_driven, 3))
    else $error("read started on an undriven strobe");
  AST_RELEASE_ENDS: assert property (!strobe_driven [*8] |-> !read_active)
    else $error("read still active after release");
  AST_VALID_PULSE: assert property (read_valid |=> !read_valid)
    else $error("valid held longer than one cycle");
  ////////////////////////////////////////////////////////////////////////////////
  COV_POL_HIGH: cover property ($rose(read_active) && sync_clock_polarity);
  COV_POL_LOW: cover property ($rose(read_active) && !sync_clock_polarity);
  COV_VALID: cover property (read_valid);
  COV_CODE_MOVE: cover property ($changed(active_cal_code));
endmodule // ddr_strobe_read_capture_sva
bind ddr_strobe_read_capture ddr_strobe_read_capture_sva ddr_strobe_read_capture_sva_i (
  .clk(clk), .reset(reset), .strobe_in(strobe_in), .strobe_driven(strobe_driven), .read_valid(read_valid),
  .read_active(read_active), .sync_clock_polarity(sync_clock_polarity), .active_cal_code(active_cal_code),
  .write_transfer_strobe(write_transfer_strobe));

// File: verification/memory_strobe_model.sv
// memory side model driving strobe and read data
`timescale 1ns/1ns
module memory_strobe_model (
  input  wire        clk,
  output reg         strobe_in,
  output reg         strobe_driven,
  output reg  [17:0] read_data_in
);
  integer i;
  initial begin
    strobe_in = 1'b1;
    strobe_driven = 1'b0;
    read_data_in = 18'h0;
  end
  // released data pads keep changing
  always @(negedge clk) if (!strobe_driven) read_data_in <= ~read_data_in;
  task burst(input integer n, input integer h, input [17:0] base);
    begin
      @(negedge clk) strobe_driven = 1'b1;
      @(negedge clk) strobe_in = 1'b0;
      repeat (2 * h) @(negedge clk);
      for (i = 0; i < 2 * n; i = i + 1) begin
        strobe_in = ~i[0];
        read_data_in = base + i[17:0];
        repeat (h) @(negedge clk);
      end
      strobe_in = 1'b0;
      repeat (10) @(negedge clk);
      strobe_driven = 1'b0;
      strobe_in = 1'b1;
    end
  endtask
  // strobe glitches with nobody driving
  task noise;
    for (i = 0; i < 4; i = i + 1) begin
      repeat (3) @(negedge clk);
      strobe_in = ~strobe_in;
    end
  endtask
endmodule // memory_strobe_model

// File: verification/test_ddr_strobe_read_capture.sv
// self-checking bench for the strobe read capture block
`timescale 1ns/1ns
module test_ddr_strobe_read_capture;
  reg  clk = 1'b0, reset = 1'b1, edge_clock_one = 1'b0, half_select = 1'b0, was_hi = 1'b0, was_ws = 1'b0;
  reg  fb_early_a = 1'b0, fb_late_a = 1'b0, fb_early_b = 1'b0, fb_late_b = 1'b0;
  reg  [17:0] hi = 18'h0, lo = 18'h0, base;
  wire strobe_in, strobe_driven, read_valid, sync_clock_polarity, read_active;
  wire [17:0] read_data_in, read_rise_data, read_fall_data, write_data_out, write_transfer_strobe;
  wire [5:0]  active_cal_code;
  integer     n_errors = 0, n_tests = 0, seed = 45485, r, k, n, h, lag = 0;
  reg  [35:0] got_q[$];
  ddr_strobe_read_capture ddr_strobe_read_capture_i (.clk(clk), .reset(reset), .strobe_in(strobe_in),
    .strobe_driven(strobe_driven), .read_data_in(read_data_in), .edge_clock_one(edge_clock_one),
    .out_data_high_phase(hi), .out_data_low_phase(lo), .half_select(half_select), .fb_early_a(fb_early_a),
    .fb_late_a(fb_late_a), .fb_early_b(fb_early_b), .fb_late_b(fb_late_b), .read_rise_data(read_rise_data),
    .read_fall_data(read_fall_data), .read_valid(read_valid), .sync_clock_polarity(sync_clock_polarity),
    .active_cal_code(active_cal_code), .write_data_out(write_data_out),
    .write_transfer_strobe(write_transfer_strobe), .read_active(read_active));
  memory_strobe_model memory_strobe_model_i (.clk(clk), .strobe_in(strobe_in), .strobe_driven(strobe_driven),
    .read_data_in(read_data_in));
  always #50 clk = ~clk;
  initial begin
    #23;
    forever #400 edge_clock_one = ~edge_clock_one;
  end
  always @(negedge clk) if (read_valid === 1'b1) got_q.push_back({read_rise_data, read_fall_data});
  ////////////////////////////////////////////////////////////////////////////////
  function [35:0] beat_pair(input [17:0] b, input integer k);
    beat_pair = {b + 18'h2 * k[17:0], b + 18'h2 * k[17:0] + 18'h1};
  endfunction
  task chk(input [35:0] got, input [35:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk(active_cal_code, 6'h20);
    chk({read_active, read_valid, sync_clock_polarity}, 3'b000);
    fb_early_a = 1'b1;
    repeat (200) @(negedge clk);
    chk(active_cal_code, 6'h3F);
    fb_early_a = 1'b0;
    fb_late_a = 1'b1;
    repeat (300) @(negedge clk);
    chk(active_cal_code, 6'h00);
    fb_late_a = 1'b0;
    half_select = 1'b1;
    repeat (8) @(negedge clk);
    chk(active_cal_code, 6'h20);
    half_select = 1'b0;
    memory_strobe_model_i.noise;
    repeat (10) @(negedge clk);
    chk({read_active, got_q.size() == 0}, 2'b01);
    fb_early_b = 1'b1;
    for (r = 0; r < 4; r = r + 1) begin
      n = (r == 0) ? 1 : 1 + {$random(seed)} % 4;
      h = 5 + {$random(seed)} % 3;
      base = $random(seed);
      got_q.delete();
      memory_strobe_model_i.burst(n, h, base);
      repeat (30) @(negedge clk);
      chk({read_active, active_cal_code}, 7'h00);
      chk(got_q.size(), n);
      for (k = 0; k < n && got_q.size() > 0; k = k + 1) chk(got_q.pop_front(), beat_pair(base, k));
    end
    half_select = 1'b1;
    repeat (8) @(negedge clk);
    chk(active_cal_code, 6'h3F);
    hi = $random(seed);
    lo = ~hi;
    repeat (20) @(negedge clk);
    k = 0;
    for (r = 0; r < 64; r = r + 1) begin
      @(negedge clk);
      chk(write_data_out === hi || write_data_out === lo, 1'b1);
      if (write_data_out === hi) k = k + 1;
      lag = (write_data_out === hi && !was_hi) ? 0 : lag + 1;
      if (write_transfer_strobe[0] === 1'b1 && !was_ws && r > 10) chk(lag >= 1 && lag <= 3, 1'b1);
      was_hi = write_data_out === hi;
      was_ws = write_transfer_strobe[0];
    end
    chk(k > 16 && k < 48, 1'b1);
    wrap_up;
  end
endmodule // test_ddr_strobe_read_capture
